/* File: core/acrb_regbank.sv */
/*
 configuration register bank of the 24-bit converter: identity, options, calibration
 values, pin mirror, status-word assembly and interface idle timeout.
 assumes the spi command decoder presents single-cycle read/write strobes on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module acrb_regbank (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire acrb_pkg::acrb_req_s req,
    output logic [7:0]              rdata,
    output logic                    rvalid,
    input  wire acrb_pkg::acrb_pins_s pins,
    input  wire logic               sclk_active,
    output logic                    iface_reset,
    input  wire logic [7:0]         crc_value,
    input  wire logic               input_out_of_range,
    output logic                    status_word_enable,
    output logic [7:0]              status_word,
    output acrb_pkg::acrb_cfg_s     cfg
);

    logic [7:0] options;
    logic [7:0] ofs_low;
    logic [7:0] ofs_mid;
    logic [7:0] ofs_high;
    logic [7:0] gain_low;
    logic [7:0] gain_high;
    logic [7:0] next_options;
    logic [7:0] next_ofs_low;
    logic [7:0] next_ofs_mid;
    logic [7:0] next_ofs_high;
    logic [7:0] next_gain_low;
    logic [7:0] next_gain_high;
    logic [7:0] next_rdata;
    logic       next_rvalid;
    logic [7:0] next_status;
    logic       spi_mode;
    logic       wr_ok;
    logic [7:0] ident;
    logic [7:0] mirror;

    // access allowed only when the pins select spi
    assign spi_mode = (pins.interface_type == acrb_pkg::IFACE_SPI);
    assign wr_ok    = req.wr && spi_mode;

    // fixed identity and live pin mirror
    assign ident  = {acrb_pkg::REVISION_DEFAULT, acrb_pkg::FAMILY_CODE_DEFAULT};
    assign mirror = {1'b0, pins.resolution_mode, pins.oversampling_ratio,
                     pins.filter_type, pins.interface_type, pins.framesync_role};

    // register write decode
    always_comb begin
        next_options   = options;
        next_ofs_low   = ofs_low;
        next_ofs_mid   = ofs_mid;
        next_ofs_high  = ofs_high;
        next_gain_low  = gain_low;
        next_gain_high = gain_high;
        if (wr_ok) begin
            if (req.addr == acrb_pkg::ADDR_OPTIONS) begin
                next_options = req.wdata & acrb_pkg::OPTIONS_WRITE_MASK;
            end else if (req.addr == acrb_pkg::ADDR_OFS_LOW) begin
                next_ofs_low = req.wdata;
            end else if (req.addr == acrb_pkg::ADDR_OFS_MID) begin
                next_ofs_mid = req.wdata;
            end else if (req.addr == acrb_pkg::ADDR_OFS_HIGH) begin
                next_ofs_high = req.wdata;
            end else if (req.addr == acrb_pkg::ADDR_GAIN_LOW) begin
                next_gain_low = req.wdata;
            end else if (req.addr == acrb_pkg::ADDR_GAIN_HIGH) begin
                next_gain_high = req.wdata;
            end
            // identity and mirror writes fall through unchanged
        end
    end

    // read decode, answered one cycle after the strobe
    always_comb begin
        next_rvalid = req.rd && spi_mode;
        next_rdata  = 8'h00;
        if (next_rvalid) begin
            if (req.addr == acrb_pkg::ADDR_PART_IDENT) begin
                next_rdata = ident;
            end else if (req.addr == acrb_pkg::ADDR_OPTIONS) begin
                next_rdata = options;
            end else if (req.addr == acrb_pkg::ADDR_OFS_LOW) begin
                next_rdata = ofs_low;
            end else if (req.addr == acrb_pkg::ADDR_OFS_MID) begin
                next_rdata = ofs_mid;
            end else if (req.addr == acrb_pkg::ADDR_OFS_HIGH) begin
                next_rdata = ofs_high;
            end else if (req.addr == acrb_pkg::ADDR_GAIN_LOW) begin
                next_rdata = gain_low;
            end else if (req.addr == acrb_pkg::ADDR_GAIN_HIGH) begin
                next_rdata = gain_high;
            end else begin
                next_rdata = mirror;
            end
        end
    end

    // status word contents
    always_comb begin
        if (options[acrb_pkg::BIT_STAT_SEL]) begin
            next_status = crc_value;
        end else begin
            next_status = {crc_value[3:0], input_out_of_range, 3'h0};
        end
    end

    // register storage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            options     <= acrb_pkg::RST_OPTIONS;
            ofs_low     <= acrb_pkg::RST_OFS_BYTE;
            ofs_mid     <= acrb_pkg::RST_OFS_BYTE;
            ofs_high    <= acrb_pkg::RST_OFS_BYTE;
            gain_low    <= acrb_pkg::RST_GAIN_LOW;
            gain_high   <= acrb_pkg::RST_GAIN_HIGH;
            rdata       <= 8'h00;
            rvalid      <= 1'b0;
            status_word <= 8'h00;
        end else begin
            options     <= next_options;
            ofs_low     <= next_ofs_low;
            ofs_mid     <= next_ofs_mid;
            ofs_high    <= next_ofs_high;
            gain_low    <= next_gain_low;
            gain_high   <= next_gain_high;
            rdata       <= next_rdata;
            rvalid      <= next_rvalid;
            status_word <= next_status;
        end
    end

    // configuration handed to the datapath
    assign cfg.gain_correction_enable   = options[acrb_pkg::BIT_GAIN_EN];
    assign cfg.offset_correction_enable = options[acrb_pkg::BIT_OFS_EN];
    assign cfg.idle_timeout_length      = options[acrb_pkg::BIT_TOUT_LEN];
    assign cfg.idle_timeout_enable      = options[acrb_pkg::BIT_TOUT_EN];
    assign cfg.status_word_disable      = options[acrb_pkg::BIT_STAT_DIS];
    assign cfg.status_word_select       = options[acrb_pkg::BIT_STAT_SEL];
    assign cfg.offset_cal_value         = {ofs_high, ofs_mid, ofs_low};
    assign cfg.gain_cal_value           = {gain_high, gain_low};

    // status word only ever omitted in spi mode
    assign status_word_enable = !(options[acrb_pkg::BIT_STAT_DIS] && spi_mode);

    // idle timer resets the serial interface
    acrb_idle_timer u_idle (
        .clk         (clk),
        .nrst        (nrst),
        .enable      (options[acrb_pkg::BIT_TOUT_EN] && spi_mode),
        .short_sel   (options[acrb_pkg::BIT_TOUT_LEN]),
        .sclk_active (sclk_active),
        .expire      (iface_reset)
    );

endmodule
`default_nettype wire

/* File: core/acrb_pkg.sv */
/*
 register bank constants and carriers for the converter configuration block.
 assumes a register access port driven by the spi command decoder, master clock domain.
*/
package acrb_pkg;

    // register addresses
    localparam logic [2:0] ADDR_PART_IDENT  = 3'h0;
    localparam logic [2:0] ADDR_OPTIONS     = 3'h1;
    localparam logic [2:0] ADDR_OFS_LOW     = 3'h2;
    localparam logic [2:0] ADDR_OFS_MID     = 3'h3;
    localparam logic [2:0] ADDR_OFS_HIGH    = 3'h4;
    localparam logic [2:0] ADDR_GAIN_LOW    = 3'h5;
    localparam logic [2:0] ADDR_GAIN_HIGH   = 3'h6;
    localparam logic [2:0] ADDR_PIN_MIRROR  = 3'h7;

    // converter_options field positions
    localparam int BIT_GAIN_EN      = 5;
    localparam int BIT_OFS_EN       = 4;
    localparam int BIT_TOUT_LEN     = 3;
    localparam int BIT_TOUT_EN      = 2;
    localparam int BIT_STAT_DIS     = 1;
    localparam int BIT_STAT_SEL     = 0;
    localparam logic [7:0] OPTIONS_WRITE_MASK = 8'h3f;

    // part identification fields
    localparam int REV_LSB = 3;
    localparam logic [2:0] FAMILY_CODE_DEFAULT = 3'h5; // arbitrary value
    localparam logic [4:0] REVISION_DEFAULT    = 5'h01; // arbitrary value

    // reset values
    localparam logic [7:0] RST_OPTIONS   = 8'h00;
    localparam logic [7:0] RST_OFS_BYTE  = 8'h00;
    localparam logic [7:0] RST_GAIN_LOW  = 8'h00;
    localparam logic [7:0] RST_GAIN_HIGH = 8'h80;

    // interface idle timeout in master-clock periods
    localparam int TOUT_LONG_LOG2  = 16;
    localparam int TOUT_SHORT_LOG2 = 14;
    localparam logic [16:0] TOUT_LONG_CYC  = 17'h10000;
    localparam logic [16:0] TOUT_SHORT_CYC = 17'h04000;

    // status word layout, crc-4 form
    localparam int STAT_CRC4_LSB = 4;
    localparam int STAT_RANGE_BIT = 3;

    // interface type encoding of the mirror
    localparam logic IFACE_SPI = 1'b0;

    // read/write request from the serial command decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } acrb_req_s;

    // hardware mode pins as mirrored
    typedef struct packed {
        logic       resolution_mode;
        logic [1:0] oversampling_ratio;
        logic [1:0] filter_type;
        logic       interface_type;
        logic       framesync_role;
    } acrb_pins_s;

    // decoded configuration for the datapath
    typedef struct packed {
        logic        gain_correction_enable;
        logic        offset_correction_enable;
        logic        idle_timeout_length;
        logic        idle_timeout_enable;
        logic        status_word_disable;
        logic        status_word_select;
        logic [23:0] offset_cal_value;
        logic [15:0] gain_cal_value;
    } acrb_cfg_s;

endpackage

/* File: core/acrb_idle_timer.sv */
/*
 serial clock idle timer: pulses when sclk stays idle for the selected length.
 assumes sclk_active is a master-clock-synchronous level marking sclk activity.
*/
`timescale 1ns/1ps
`default_nettype none
module acrb_idle_timer (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic enable,
    input  wire logic short_sel,
    input  wire logic sclk_active,
    output logic      expire
);

    logic [16:0] count;
    logic [16:0] next_count;
    logic        next_expire;
    logic [16:0] limit;

    // count idle cycles, restart on activity or when disabled
    always_comb begin
        limit       = short_sel ? acrb_pkg::TOUT_SHORT_CYC : acrb_pkg::TOUT_LONG_CYC;
        next_count  = count;
        next_expire = 1'b0;
        if (!enable || sclk_active) begin
            next_count = 17'h00000;
        end else if (count == limit - 17'h00001) begin
            next_count  = 17'h00000;
            next_expire = 1'b1;
        end else begin
            next_count = count + 17'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count  <= 17'h00000;
            expire <= 1'b0;
        end else begin
            count  <= next_count;
            expire <= next_expire;
        end
    end

endmodule
`default_nettype wire

/* File: sim/acrb_regbank_chk.sv */
/*
 port checker for the register bank.
 assumes one clock, sync active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module acrb_regbank_chk (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire acrb_pkg::acrb_req_s  req,
    input  wire logic [7:0]           rdata,
    input  wire logic                 rvalid,
    input  wire acrb_pkg::acrb_pins_s pins,
    input  wire logic                 iface_reset,
    input  wire logic [7:0]           crc_value,
    input  wire logic                 input_out_of_range,
    input  wire logic                 status_word_enable,
    input  wire logic [7:0]           status_word,
    input  wire acrb_pkg::acrb_cfg_s  cfg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // read strobe taken in spi mode
    logic rd_ok;
    assign rd_ok = req.rd && !pins.interface_type;

    // read answer timing
    property p_rd; rd_ok |=> rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_fs; req.rd && pins.interface_type |=> !rvalid; endproperty
    a_fs: assert property (p_fs) else $error("frame-sync read answered");
    // read-only contents
    property p_id; rd_ok && req.addr == acrb_pkg::ADDR_PART_IDENT |=>
        rdata == {acrb_pkg::REVISION_DEFAULT, acrb_pkg::FAMILY_CODE_DEFAULT}; endproperty
    a_id: assert property (p_id) else $error("identity wrong");
    property p_mir; rd_ok && req.addr == acrb_pkg::ADDR_PIN_MIRROR |=>
        rdata == {1'b0, $past(pins)}; endproperty
    a_mir: assert property (p_mir) else $error("mirror wrong");
    // calibration write lands next cycle
    property p_gain; req.wr && !pins.interface_type && req.addr == acrb_pkg::ADDR_GAIN_LOW
        |=> cfg.gain_cal_value[7:0] == $past(req.wdata); endproperty
    a_gain: assert property (p_gain) else $error("gain low not stored");
    // status word layout and enable
    property p_crc4; !cfg.status_word_select |=> status_word ==
        (($past(crc_value) << 4) | 8'({$past(input_out_of_range), 3'h0})); endproperty
    a_crc4: assert property (p_crc4) else $error("crc-4 word wrong");
    property p_en; status_word_enable == !(cfg.status_word_disable && !pins.interface_type);
    endproperty
    a_en: assert property (p_en) else $error("status enable wrong");
    // no idle reset while timeout is off
    property p_tout; !cfg.idle_timeout_enable [*2] |-> !iface_reset; endproperty
    a_tout: assert property (p_tout) else $error("idle reset while off");
endmodule
bind acrb_regbank acrb_regbank_chk i_chk (.clk, .nrst, .req, .rdata, .rvalid, .pins,
    .iface_reset, .crc_value, .input_out_of_range, .status_word_enable, .status_word, .cfg);
`default_nettype wire

/* File: sim/acrb_host.sv */
/*
 host model: one register access per call.
 assumes strobes change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module acrb_host (
    input  wire logic                clk,
    input  wire logic [7:0]          rdata,
    input  wire logic                rvalid,
    output var acrb_pkg::acrb_req_s  req
);
    initial req = '0;
    // strobe over one edge, then release with inverted lines
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        @(negedge clk);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = rdata;
        v = rvalid;
    endtask
endmodule
`default_nettype wire

/* File: sim/acrb_regbank_bench.sv */
/*
 self-checking bench for the register bank.
 assumes the host model in acrb_host.
*/
`timescale 1ns/1ps
`default_nettype none
module acrb_regbank_bench;
    logic                 clk;
    logic                 nrst;
    acrb_pkg::acrb_req_s  req;
    logic [7:0]           rdata;
    logic                 rvalid;
    acrb_pkg::acrb_pins_s pins;
    logic                 sclk_active;
    logic                 iface_reset;
    logic [7:0]           crc_value;
    logic                 input_out_of_range;
    logic                 status_word_enable;
    logic [7:0]           status_word;
    acrb_pkg::acrb_cfg_s  cfg;
    logic [7:0]           q;
    logic                 v;
    logic [7:0]           rv [8];
    int                   n_errors = 0;
    int                   num_checks = 0;
    int                   cyc = 0;
    int                   n;
    int                   len;

    acrb_regbank i_dut (.clk, .nrst, .req, .rdata, .rvalid, .pins, .sclk_active,
        .iface_reset, .crc_value, .input_out_of_range, .status_word_enable,
        .status_word, .cfg);
    acrb_host i_host (.clk, .rdata, .rvalid, .req);

    // clock and hang ceiling
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [47:0] e, input logic [47:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, q, v);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        i_host.access(1'b0, a, 8'h00, q, v);
        chk("rvalid", 48'h1, 48'(v));
        chk("rdata", 48'(e), 48'(q));
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        pins = 7'h59;
        sclk_active = 1'b1;
        crc_value = 8'hb7;
        input_out_of_range = 1'b1;
        rv = '{8'h0d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h59};
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), rv[a]);
        for (int a = 0; a < 8; a++) wr(3'(a), 8'hff);
        for (int a = 1; a < 7; a++) rv[a] = (a == 1) ? 8'h3f : 8'hff;
        for (int a = 0; a < 8; a++) rd(3'(a), rv[a]);
        for (int a = 2; a < 7; a++) wr(3'(a), 8'(a * 8'h11));
        chk("offset", 48'h443322, 48'(cfg.offset_cal_value));
        chk("gain", 48'h6655, 48'(cfg.gain_cal_value));
        // each option bit alone
        for (int b = 0; b < 6; b++) begin
            wr(3'h1, 8'(1 << b));
            @(negedge clk);
            chk("options", 48'(1 << b), 48'(cfg[45:40]));
            chk("status enable", 48'(b != 1), 48'(status_word_enable));
            chk("status word", (b == 0) ? 48'hb7 : 48'h78, 48'(status_word));
        end
        // frame-sync mode refuses access
        pins = 7'h5b;
        wr(3'h2, 8'h00);
        i_host.access(1'b0, 3'h2, 8'h00, q, v);
        chk("rvalid fs", 48'h0, 48'(v));
        pins = 7'h59;
        rd(3'h2, 8'h22);
        // idle timeout, long then short
        for (int s = 0; s < 2; s++) begin
            len = s ? 16384 : 65536;
            wr(3'h1, s ? 8'h0c : 8'h04);
            sclk_active = 1'b0;
            n = 0;
            while (iface_reset !== 1'b1 && n < 70000) begin
                @(negedge clk);
                n++;
            end
            sclk_active = 1'b1;
            chk("idle cycles", 48'h1, 48'(n > len - 4 && n < len + 4));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
